// [pkg/led_i2c_pkg.sv]
// constants, types and state encoding for the led driver serial port
package led_i2c_pkg;

   localparam int          NUM_REGS    = 23;
   localparam logic [6:0]  SLAVE_ADDR  = 7'h70;
   localparam logic [7:0]  REG_RST     = 8'h00;

   localparam logic [7:0]  REG_BL_EN   = 8'h00;
   localparam logic [7:0]  REG_BANK_EN = 8'h01;
   localparam logic [7:0]  REG_LDO_EN  = 8'h0f;
   localparam logic [7:0]  REG_ADC_VAL = 8'h13;
   localparam logic [7:0]  REG_ADC_HI  = 8'h14;
   localparam logic [7:0]  REG_ADC_LO  = 8'h15;

   localparam int          BL_LO_W     = 6;
   localparam int          BL_HI_W     = 2;
   localparam int          REF_EN_BIT  = 3;

   localparam int          CLK_PERIOD_NS = 5;
   localparam int          SHDN_TIME_NS  = 1000000;
   localparam int          SHDN_W        = 18;
   localparam logic [SHDN_W-1:0] SHDN_CYC_DEF =
      SHDN_W'((SHDN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam int          NSYNC       = 4;
   // idle pin levels: bus lines and enable high, overheat low
   localparam logic [NSYNC-1:0] SYNC_RST = 4'h7;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
      logic en;
      logic hot;
   } line_evt_s;

   typedef enum logic [3:0] {
      st_idle,
      st_addr,
      st_ack,
      st_reg,
      st_wdata,
      st_rdata,
      st_mack,
      st_rload,
      st_ignore
   } port_state_e;

endpackage

// [rtl/led_line_sync.sv]
// pin synchronisers and bus condition detection
`timescale 1ns/100ps
`default_nettype none
module led_line_sync
   import led_i2c_pkg::*;
(
   input  wire logic  sys_clk_i, // system clock
   input  wire logic  srst_i,    // sync reset, active high
   input  wire logic  scl_i,     // bus clock pin
   input  wire logic  sda_i,     // bus data pin
   input  wire logic  en_i,      // enable pin
   input  wire logic  hot_i,     // overheat flag
   output line_evt_s  ev_o       // synced levels and events
);

   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] meta;
   logic [NSYNC-1:0] sync;
   logic [NSYNC-1:0] next_meta;
   logic [NSYNC-1:0] next_sync;
   logic             prev_scl;
   logic             prev_sda;
   logic             next_prev_scl;
   logic             next_prev_sda;

   assign pins = {hot_i, en_i, sda_i, scl_i};

   // two stages on every pin; fast enough for both bus rates at 5 ns
   always_comb begin // R03
      next_meta     = pins;
      next_sync     = meta;
      next_prev_scl = sync[0];
      next_prev_sda = sync[1];
   end

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               // a high overheat stage here would flash outputs off after reset
               meta[g] <= SYNC_RST[g];
               sync[g] <= SYNC_RST[g];
            end else begin
               meta[g] <= next_meta[g];
               sync[g] <= next_sync[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
      end else begin
         prev_scl <= next_prev_scl;
         prev_sda <= next_prev_sda;
      end
   end

   always_comb begin // R09
      ev_o.scl_rise = sync[0] & ~prev_scl;
      ev_o.scl_fall = ~sync[0] & prev_scl;
      ev_o.start    = sync[0] & prev_scl & prev_sda & ~sync[1];
      ev_o.stop     = sync[0] & prev_scl & ~prev_sda & sync[1];
      ev_o.sda      = sync[1];
      ev_o.en       = sync[2];
      ev_o.hot      = sync[3];
   end

endmodule
`default_nettype wire

// [rtl/led_i2c_port.sv]
// serial slave port with register file, shutdown, sleep and converter window
// Functional notes
// R01 - only seven-bit slave addresses are decoded
// R02 - answer write E0h and read E1h only
// R03 - work at 100 and 400 kbit/s
// R04 - write: address, register, data, all acknowledged
// R05 - combined read returns pointed byte, master NACKs
// R06 - pointer kept across stops and foreign traffic
// R07 - pointer never increments or decrements
// R08 - twenty-three eight-bit registers, read and write; register 13h ignores bus writes and takes only converter results
// R09 - start or repeated start begins a transaction
// R10 - enable low long enough resets all registers
// R11 - all backlights off means sleep, port alive
// R12 - sleep keeps register contents
// R13 - overheat disables outputs, registers kept
// R14 - interrupt when reading leaves threshold window
// R15 - converter runs only with reference regulator on
// R16 - foreign addresses ignored, pointer untouched
`timescale 1ns/100ps
`default_nettype none
module led_i2c_port
   import led_i2c_pkg::*;
#(
   parameter logic [SHDN_W-1:0] SHDN_CYCLES = SHDN_CYC_DEF
) (
   input  wire logic       sys_clk_i,             // system clock, 200 MHz
   input  wire logic       srst_i,                // sync reset, active high
   input  wire logic       scl_i,                 // bus clock pin
   input  wire logic       sda_i,                 // bus data pin level
   output logic            sda_o,                 // data pin drive level
   output logic            sda_oe_n_o,            // low while pulling data low
   input  wire logic       enable_i,              // enable pin
   input  wire logic       overheat_protection_i, // junction too hot
   input  wire logic [7:0] adc_data_i,            // converter result
   input  wire logic       adc_valid_i,           // result strobe
   output logic            adc_run_o,             // converter may run
   output logic            irq_n_o,               // window interrupt, low
   output logic            sleep_o,               // all backlights off
   output logic            outputs_off_o,         // outputs disabled
   output logic            shutdown_o             // device shut down
);

   line_evt_s           ev;
   port_state_e         state;
   port_state_e         next_state;
   port_state_e         after_ack;
   port_state_e         next_after;
   logic [2:0]          cnt;
   logic [2:0]          next_cnt;
   logic [7:0]          shreg;
   logic [7:0]          next_shreg;
   logic [7:0]          ptr;
   logic [7:0]          next_ptr;
   logic                ack_on;
   logic                next_ack_on;
   logic                next_oe_n;
   logic [7:0]          regs [NUM_REGS];
   logic [7:0]          next_regs [NUM_REGS];
   logic [SHDN_W-1:0]   shdn_cnt;
   logic [SHDN_W-1:0]   next_shdn_cnt;
   logic                shut;
   logic                next_shut;
   logic                next_irq_n;
   logic                next_sleep;
   logic                next_off;
   logic                next_run;
   logic [7:0]          rx_byte;
   logic [7:0]          rd_byte;
   logic                load_rd;
   logic                adc_en;
   logic                out_win;
   logic                all_off;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a < 8'(NUM_REGS));
   endfunction

   led_line_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .en_i      (enable_i),
      .hot_i     (overheat_protection_i),
      .ev_o      (ev)
   );

   assign rx_byte = {shreg[6:0], ev.sda};
   // unmapped pointer reads as zero rather than aliasing
   assign rd_byte = reg_hit(ptr) ? regs[ptr[4:0]] : 8'h00; // R08
   assign adc_en  = regs[REG_LDO_EN[4:0]][REF_EN_BIT]; // R15
   assign out_win = adc_en &&
                    ((regs[REG_ADC_VAL[4:0]] > regs[REG_ADC_HI[4:0]]) ||
                     (regs[REG_ADC_VAL[4:0]] < regs[REG_ADC_LO[4:0]])); // R14
   assign all_off = (regs[REG_BL_EN[4:0]][BL_LO_W-1:0] == '0) &&
                    (regs[REG_BANK_EN[4:0]][BL_HI_W-1:0] == '0);

   // port sequencing and register file
   always_comb begin
      next_state  = state;
      next_after  = after_ack;
      next_cnt    = cnt;
      next_shreg  = shreg;
      next_ptr    = ptr;
      next_ack_on = ack_on;
      next_oe_n   = sda_oe_n_o;
      next_regs   = regs;
      load_rd     = 1'b0;
      if (ev.start) begin // R09
         next_state  = st_addr;
         next_cnt    = 3'd0;
         next_ack_on = 1'b0;
         next_oe_n   = 1'b1;
      end else if (ev.stop) begin
         next_state = st_idle;
         next_oe_n  = 1'b1;
      end else begin
         unique case (state)
            st_idle, st_ignore: begin
            end
            st_addr, st_reg, st_wdata: begin
               if (ev.scl_rise) begin
                  next_shreg = rx_byte;
                  next_cnt   = 3'(cnt + 3'd1);
                  if (cnt == 3'd7) begin
                     next_state  = st_ack;
                     next_ack_on = 1'b0;
                     if (state == st_addr) begin
                        // only the seven-bit form is compared
                        if (rx_byte[7:1] != SLAVE_ADDR) begin // R01
                           next_state = st_ignore; // R16
                        end
                        next_after = rx_byte[0] ? st_rload : st_reg; // R02
                     end else if (state == st_reg) begin
                        next_ptr   = rx_byte; // R06
                        next_after = st_wdata;
                     end else begin
                        if (reg_hit(ptr) && ptr != REG_ADC_VAL) begin
                           next_regs[ptr[4:0]] = rx_byte; // R04
                        end
                        // single byte per access, no pointer step
                        next_after = st_ignore; // R07
                     end
                  end
               end
            end
            st_ack: begin
               if (ev.scl_fall) begin
                  if (!ack_on) begin
                     next_ack_on = 1'b1;
                     next_oe_n   = 1'b0; // R04
                  end else begin
                     next_ack_on = 1'b0;
                     next_oe_n   = 1'b1;
                     next_cnt    = 3'd0;
                     next_state  = after_ack;
                     load_rd     = (after_ack == st_rload); // R05
                  end
               end
            end
            st_rdata: begin
               if (ev.scl_fall) begin
                  if (cnt == 3'd7) begin
                     next_oe_n  = 1'b1;
                     next_state = st_mack;
                  end else begin
                     next_cnt   = 3'(cnt + 3'd1);
                     next_shreg = {shreg[6:0], 1'b0};
                     next_oe_n  = shreg[6];
                  end
               end
            end
            st_mack: begin
               if (ev.scl_rise) begin
                  // NACK ends the read; ACK repeats the same register
                  next_state = ev.sda ? st_ignore : st_rload; // R05 R07
               end
            end
            st_rload: begin
               load_rd = ev.scl_fall;
            end
         endcase
      end
      if (load_rd) begin
         next_shreg = rd_byte; // R05
         next_oe_n  = rd_byte[7];
         next_cnt   = 3'd0;
         next_state = st_rdata;
      end
      // converter result lands only while its reference is up
      if (adc_valid_i && adc_en) begin // R15
         next_regs[REG_ADC_VAL[4:0]] = adc_data_i;
      end
      if (shut) begin // R10
         next_state = st_idle;
         next_ptr   = 8'h00;
         next_oe_n  = 1'b1;
         for (int i = 0; i < NUM_REGS; i++) begin
            next_regs[i] = REG_RST;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state      <= st_idle;
         after_ack  <= st_idle;
         cnt        <= 3'd0;
         shreg      <= 8'h00;
         ptr        <= 8'h00;
         ack_on     <= 1'b0;
         sda_oe_n_o <= 1'b1;
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= REG_RST;
         end
      end else begin
         state      <= next_state;
         after_ack  <= next_after;
         cnt        <= next_cnt;
         shreg      <= next_shreg;
         ptr        <= next_ptr;
         ack_on     <= next_ack_on;
         sda_oe_n_o <= next_oe_n;
         regs       <= next_regs;
      end
   end

   // power state and status outputs
   always_comb begin
      next_shdn_cnt = shdn_cnt;
      next_shut     = shut;
      if (ev.en) begin
         next_shdn_cnt = '0;
         next_shut     = 1'b0;
      end else if (shdn_cnt >= SHDN_CYCLES) begin
         next_shut = 1'b1; // R10
      end else begin
         next_shdn_cnt = SHDN_W'(shdn_cnt + 1'b1);
      end
      // sleep is only a status; the register file is untouched
      next_sleep = all_off && !shut; // R11 R12
      // overheat gates outputs alone, registers keep their values
      next_off   = shut || ev.hot; // R13
      next_irq_n = !out_win; // R14
      next_run   = adc_en && !shut; // R15
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         shdn_cnt      <= '0;
         shut          <= 1'b0;
         shutdown_o    <= 1'b0;
         sleep_o       <= 1'b0;
         outputs_off_o <= 1'b0;
         irq_n_o       <= 1'b1;
         adc_run_o     <= 1'b0;
         sda_o         <= 1'b0;
      end else begin
         shdn_cnt      <= next_shdn_cnt;
         shut          <= next_shut;
         shutdown_o    <= next_shut;
         sleep_o       <= next_sleep;
         outputs_off_o <= next_off;
         irq_n_o       <= next_irq_n;
         adc_run_o     <= next_run;
         sda_o         <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_addr_done;
      state == st_addr && ev.scl_rise && cnt == 3'd7 && !ev.start && !ev.stop && !shut;
   endsequence

   sequence s_ack_release;
      state == st_ack && ack_on && ev.scl_fall && !ev.start && !ev.stop && !shut;
   endsequence

   property p_addr_miss;
      s_addr_done ##0 (rx_byte[7:1] != SLAVE_ADDR) |=> state == st_ignore;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address taken"); // R16
   property p_addr_hit;
      s_addr_done ##0 (rx_byte[7:1] == SLAVE_ADDR)
         |=> state == st_ack && sda_oe_n_o;
   endproperty
   a_addr_hit: assert property (p_addr_hit) else $error("own address missed"); // R02
   property p_ignore_quiet;
      state == st_ignore |-> sda_oe_n_o;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("drive while ignoring"); // R16
   property p_ptr_hold;
      !(state == st_reg && ev.scl_rise && cnt == 3'd7) && !shut |=> $stable(ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved"); // R06
   property p_store;
      state == st_wdata && ev.scl_rise && cnt == 3'd7 && !ev.start && !ev.stop
         && !shut && reg_hit(ptr) && ptr != REG_ADC_VAL
         |=> regs[$past(ptr[4:0])] == $past(rx_byte);
   endproperty
   a_store: assert property (p_store) else $error("write not stored"); // R04
   property p_read_ack;
      s_ack_release ##0 (after_ack == st_rload)
         |=> state == st_rdata && sda_oe_n_o == $past(rd_byte[7]);
   endproperty
   a_read_ack: assert property (p_read_ack) else $error("read byte not driven"); // R05
   property p_start;
      ev.start && !shut |=> state == st_addr && cnt == 3'd0;
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // R09
   property p_window;
      out_win |=> !irq_n_o;
   endproperty
   a_window: assert property (p_window) else $error("interrupt missing"); // R14
   property p_adc_gate;
      !adc_en && !shut |=> $stable(regs[REG_ADC_VAL[4:0]]) && !adc_run_o;
   endproperty
   a_adc_gate: assert property (p_adc_gate) else $error("converter ran ungated"); // R15
   property p_overheat;
      ev.hot |=> outputs_off_o;
   endproperty
   a_overheat: assert property (p_overheat) else $error("outputs left on"); // R13
   property p_shdn;
      shut |=> ptr == 8'h00 && regs[0] == REG_RST && state == st_idle;
   endproperty
   a_shdn: assert property (p_shdn) else $error("shutdown kept state"); // R10

   property p_sleep;
      all_off && !shut |=> sleep_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not flagged"); // R11

endmodule
`default_nettype wire

// [verif/i2c_host_model.sv]
// bus master model for the led driver serial port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
   output logic      scl_o, // bus clock, idle high
   output logic      sda_o, // data drive, 1 = released
   input  wire logic sda_i  // resolved data wire
);
   logic busy;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      busy  = 1'b0;
   end

   // low 32 ns, high 16 ns: data settles well past the port's sync lag
   task automatic bit_out(input logic b);
      scl_o = 1'b0;
      #16 sda_o = b;
      #16 scl_o = 1'b1;
      #16;
   endtask

   task automatic bit_in(output logic b);
      scl_o = 1'b0;
      #16 sda_o = 1'b1;
      #16 scl_o = 1'b1;
      #8 b = sda_i;
      #8;
   endtask

   // repeated start when already in a frame, clock still otherwise
   task automatic start_cond;
      if (busy) begin
         scl_o = 1'b0;
         #16 sda_o = 1'b1;
         #16 scl_o = 1'b1;
      end
      #8 sda_o = 1'b0;
      #8 busy = 1'b1;
   endtask

   task automatic stop_cond;
      scl_o = 1'b0;
      #16 sda_o = 1'b0;
      #16 scl_o = 1'b1;
      #8 sda_o = 1'b1;
      #8 busy = 1'b0;
   endtask

   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(a);
      ack = ~a;
   endtask

   task automatic byte_in(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(~more);
   endtask

   // seven-bit address only, direction in bit 0
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                     output logic [2:0] k);
      start_cond();
      byte_out({a, 1'b0}, k[2]);
      byte_out(r, k[1]);
      byte_out(d, k[0]);
      stop_cond();
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                     output logic [2:0] k);
      start_cond();
      byte_out({a, 1'b0}, k[2]);
      byte_out(r, k[1]);
      start_cond();
      byte_out({a, 1'b1}, k[0]);
      byte_in(1'b0, d);
      stop_cond();
   endtask

   task automatic ptr(input logic [6:0] a, input logic [7:0] r, output logic [1:0] k);
      start_cond();
      byte_out({a, 1'b0}, k[1]);
      byte_out(r, k[0]);
      stop_cond();
   endtask

   // master acks the first byte so a second byte follows
   task automatic rd2(input logic [6:0] a, output logic [7:0] d0, output logic [7:0] d1,
                      output logic k);
      start_cond();
      byte_out({a, 1'b1}, k);
      byte_in(1'b1, d0);
      byte_in(1'b0, d1);
      stop_cond();
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the led driver serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import led_i2c_pkg::*;
   localparam logic [SHDN_W-1:0] SHDN_SIM = 18'd20;
   localparam int                MAX_CYC  = 80000;
   logic        clk, srst, scl, sda_drv, sda_w, sda_q, oe_n, en, hot, adc_v;
   logic        run, irq_n, sleep, off, shut;
   logic [7:0]  adc_d;
   logic [7:0]  mem [0:NUM_REGS-1];
   logic [6:0]  foreign [0:3];
   logic [7:0]  vals [0:6];
   int          errors, n_tests, cyc, seed;

   assign sda_w = sda_drv & (oe_n | sda_q);

   led_i2c_port #(.SHDN_CYCLES(SHDN_SIM)) i_led_i2c_port (
      .sys_clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_q),
      .sda_oe_n_o(oe_n), .enable_i(en), .overheat_protection_i(hot),
      .adc_data_i(adc_d), .adc_valid_i(adc_v), .adc_run_o(run), .irq_n_o(irq_n),
      .sleep_o(sleep), .outputs_off_o(off), .shutdown_o(shut));

   i2c_host_model host (.scl_o(scl), .sda_o(sda_drv), .sda_i(sda_w));

   always #2.5 clk = ~clk;

   task automatic finish_test;
      $display("errors %0d, checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == MAX_CYC) begin
         errors++;
         finish_test();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] exp_rd(input logic [7:0] r);
      return (r < NUM_REGS) ? mem[r] : 8'h00;
   endfunction

   // equal to a threshold counts as inside
   function automatic logic exp_irq_n(input logic [7:0] v);
      return !(mem[REG_LDO_EN][REF_EN_BIT] && (v > mem[REG_ADC_HI] || v < mem[REG_ADC_LO]));
   endfunction

   task automatic wrc(input logic [7:0] r, input logic [7:0] d);
      logic [2:0] k;
      host.wr(SLAVE_ADDR, r, d, k);
      check("write acks", {5'h0, k}, 8'h07);
      if (r < NUM_REGS && r != REG_ADC_VAL) mem[r] = d;
   endtask

   task automatic rdc(input logic [7:0] r);
      logic [2:0] k;
      logic [7:0] d;
      host.rd(SLAVE_ADDR, r, d, k);
      check("read acks", {5'h0, k}, 8'h07);
      check("read data", d, exp_rd(r));
   endtask

   // pointer set, other slave addressed, then read back twice
   task automatic rds(input logic [7:0] r, input logic [6:0] fa);
      logic [1:0] k2;
      logic [2:0] k3;
      logic       k;
      logic [7:0] d0, d1;
      host.ptr(SLAVE_ADDR, r, k2);
      host.wr(fa, ~r, 8'h3c, k3);
      check("foreign acks", {5'h0, k3}, 8'h00);
      host.rd2(SLAVE_ADDR, d0, d1, k);
      check("read addr ack", {7'h0, k}, 8'h01);
      check("kept pointer", d0, exp_rd(r));
      check("no increment", d1, exp_rd(r));
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic adc_pulse(input logic [7:0] v);
      @(negedge clk);
      adc_d = v;
      adc_v = 1'b1;
      @(negedge clk);
      adc_v = 1'b0;
      tick(4);
   endtask

   initial begin
      seed = 32'h5e0c0ff1;
      {errors, n_tests, cyc} = '0;
      {clk, hot, adc_v, adc_d} = '0;
      {srst, en} = 2'b11;
      foreign = '{7'h50, 7'h78, 7'h71, 7'h38};
      vals = '{8'h60, 8'h90, 8'h80, 8'h40, 8'h3f, 8'h81, 8'h00};
      for (int i = 0; i < NUM_REGS; i++) mem[i] = REG_RST;
      tick(8);
      srst = 1'b0;
      tick(8);
      check("sda idle", {7'h0, oe_n}, 8'h01);
      check("off at reset", {7'h0, off}, 8'h00);
      check("irq idle", {7'h0, irq_n}, 8'h01);
      check("sleep at reset", {7'h0, sleep}, 8'h01);
      for (int r = 0; r < NUM_REGS; r++) begin
         if (r != int'(REG_ADC_VAL)) wrc(8'(r), 8'($random(seed)));
         rdc(8'(r));
      end
      for (int i = 0; i < 4; i++) rds(8'($unsigned($random(seed)) % NUM_REGS), foreign[i]);
      wrc(8'h17, 8'ha5);
      wrc(REG_ADC_VAL, 8'h5a);
      rdc(8'h17);
      rdc(REG_ADC_VAL);
      wrc(REG_BL_EN, 8'h00);
      wrc(REG_BANK_EN, 8'h02);
      tick(4);
      check("sleep off", {7'h0, sleep}, 8'h00);
      wrc(REG_BANK_EN, 8'h00);
      tick(4);
      check("sleep on", {7'h0, sleep}, 8'h01);
      rdc(8'h05);
      @(negedge clk) hot = 1'b1;
      tick(6);
      check("outputs off hot", {7'h0, off}, 8'h01);
      rdc(8'h03);
      @(negedge clk) hot = 1'b0;
      tick(6);
      check("outputs on cool", {7'h0, off}, 8'h00);
      wrc(REG_ADC_HI, 8'h80);
      wrc(REG_ADC_LO, 8'h40);
      wrc(REG_LDO_EN, 8'h00);
      check("adc run off", {7'h0, run}, 8'h00);
      adc_pulse(8'hf0);
      check("irq gated", {7'h0, irq_n}, 8'h01);
      rdc(REG_ADC_VAL);
      wrc(REG_LDO_EN, 8'h08);
      check("adc run on", {7'h0, run}, 8'h01);
      vals[6] = 8'($random(seed));
      foreach (vals[i]) begin
         adc_pulse(vals[i]);
         mem[REG_ADC_VAL] = vals[i];
         check("irq window", {7'h0, irq_n}, {7'h0, exp_irq_n(vals[i])});
         rdc(REG_ADC_VAL);
      end
      @(negedge clk) en = 1'b0;
      tick(10);
      en = 1'b1;
      tick(6);
      check("short enable low", {7'h0, shut}, 8'h00);
      en = 1'b0;
      tick(int'(SHDN_SIM) + 10);
      check("shutdown", {7'h0, shut}, 8'h01);
      check("shutdown outputs", {7'h0, off}, 8'h01);
      en = 1'b1;
      tick(8);
      check("wake", {7'h0, shut}, 8'h00);
      for (int i = 0; i < NUM_REGS; i++) mem[i] = REG_RST;
      rdc(8'h02);
      rdc(REG_ADC_HI);
      finish_test();
   end
endmodule
`default_nettype wire
